// file: pkg/hlis_regs.svh
// Register offsets, field positions and reset values of the link interrupt block
`ifndef HLIS_REGS_SVH
`define HLIS_REGS_SVH

// ****************************************************************
// Register indexes (byte address is four times the index)
// ****************************************************************
`define HLIS_IDX_L2_STATUS 16'h0b16
`define HLIS_IDX_L2_IRQ_EN 16'h0b17
`define HLIS_IDX_L2_OVS_STATUS 16'h0b18
`define HLIS_IDX_L2_OVS_EN 16'h0b19
`define HLIS_IDX_L3_STATUS 16'h0b26
`define HLIS_IDX_L3_IRQ_EN 16'h0b27
`define HLIS_IDX_SUMMARY 16'h0b40
`define HLIS_IDX_CLEAR 16'h0b41

// ****************************************************************
// Fields of the register bytes
// ****************************************************************
`define HLIS_L2_FLAG_BIT 0
`define HLIS_L2_ABORT_BIT 1
`define HLIS_L2_CHECK_BIT 2
`define HLIS_L2_OVS_BIT 0
`define HLIS_L3_RX_DONE_BIT 3
`define HLIS_L3_TX_DONE_BIT 4
`define HLIS_L3_RX_START_BIT 5
`define HLIS_L3_TX_START_BIT 6
`define HLIS_L3_KIND_BIT 7

// ****************************************************************
// Positions in the internal sticky vector (summary/clear layout)
// ****************************************************************
`define HLIS_EV_FLAG2 0
`define HLIS_EV_ABORT2 1
`define HLIS_EV_CHECK2 2
`define HLIS_EV_OVS2 3
`define HLIS_EV_RX_DONE3 4
`define HLIS_EV_TX_DONE3 5
`define HLIS_EV_RX_START3 6
`define HLIS_EV_TX_START3 7

// ****************************************************************
// Reset values and counts
// ****************************************************************
`define HLIS_RESET_BYTE 8'h00
`define HLIS_OVERSIZE_BYTES 276
`define HLIS_FLAG_OCTET 8'h7e
`define HLIS_ABORT_RUN 7

`endif

// file: pkg/hlis_pkg.sv
// Types shared by the link interrupt block
package hlis_pkg;

    typedef logic [7:0] hlis_byte_t;
    typedef logic [15:0] hlis_idx_t;

    // Bus slave answer state
    typedef enum logic [0:0] {
        HLIS_BUS_IDLE = 1'b0,
        HLIS_BUS_ACK = 1'b1
    } hlis_bus_e;

endpackage : hlis_pkg

// file: core/hlis_flag_detect.sv
// Abort run and flag octet detector on the incoming link bit stream
`timescale 1ns/10ps
`include "hlis_regs.svh"

module hlis_flag_detect (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic bit_valid,
    input wire logic bit_in,
    output logic abort_pulse,
    output logic flag_pulse
);
    import hlis_pkg::*;

    localparam logic [2:0] ABORT_LAST = 3'(`HLIS_ABORT_RUN - 1);

    hlis_byte_t shift_q, shift_d;
    logic [2:0] ones_q, ones_d;
    logic abort_d, flag_d;

    // ****************************************************************
    // Next state
    // ****************************************************************
    // Run counter saturates so one long run of ones reports one abort
    always_comb begin
        shift_d = shift_q;
        ones_d = ones_q;
        abort_d = 1'b0;
        flag_d = 1'b0;
        if (bit_valid) begin
            shift_d = {shift_q[6:0], bit_in};
            if (!bit_in) begin
                ones_d = 3'h0;
            end else if (ones_q != 3'h7) begin
                ones_d = ones_q + 3'h1;
            end
            abort_d = bit_in && (ones_q == ABORT_LAST);
            flag_d = ({shift_q[6:0], bit_in} == `HLIS_FLAG_OCTET);
        end
    end

    // Registers
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            shift_q <= `HLIS_RESET_BYTE;
            ones_q <= 3'h0;
            abort_pulse <= 1'b0;
            flag_pulse <= 1'b0;
        end else begin
            shift_q <= shift_d;
            ones_q <= ones_d;
            abort_pulse <= abort_d;
            flag_pulse <= flag_d;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    // Strobes arrive spaced out, so the check keys on the run counter
    abort_run_a: assert property (@(posedge mclk) disable iff (!rst_b)
        bit_valid && bit_in && (ones_q == ABORT_LAST) |=> abort_pulse)
        else $error("abort run of seven ones not reported");

    flag_octet_a: assert property (@(posedge mclk) disable iff (!rst_b)
        flag_pulse |-> $past(shift_d) == `HLIS_FLAG_OCTET)
        else $error("flag pulse without flag octet");

endmodule : hlis_flag_detect

// file: core/hlis_sticky.sv
// Bank of sticky event flags, set wins over clear
`timescale 1ns/10ps

module hlis_sticky #(
    parameter int N = 8
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [N-1:0] set_in,
    input wire logic [N-1:0] clr_in,
    output logic [N-1:0] flag_q
);
    logic [N-1:0] flag_d;

    // ****************************************************************
    // One flag per event
    // ****************************************************************
    // An event in the clearing cycle must not be lost, so set wins
    for (genvar i = 0; i < N; i++) begin : g_flag
        always_comb begin
            flag_d[i] = set_in[i] | (flag_q[i] & ~clr_in[i]);
        end
        always_ff @(posedge mclk) begin
            if (!rst_b) begin
                flag_q[i] <= 1'b0;
            end else begin
                flag_q[i] <= flag_d[i];
            end
        end
    end

endmodule : hlis_sticky

// file: core/hlis_top.sv
// Interrupt status and enable registers of data link controllers 2 and 3
//
// The Avalon-MM slave port was left to the implementer.
`timescale 1ns/10ps
`include "hlis_regs.svh"

// Functional notes
// - Link 2 check-sequence error interrupts only while its enable is set.
// - Link 2 raises abort on seven consecutive ones when enabled.
// - Link 2 raises idle interrupt on flag octet 0x7E when enabled.
// - Link 2 flags oversize when a received message exceeds 276 bytes.
// - Oversize status stays set until its register is read or its clear bit is written; read clears.
// - Oversize enable bit: 1 allows the interrupt, 0 suppresses it.
// - Link 3 kind bit reads 0 bit-oriented, 1 message-oriented.
// - Link 3 transmit sets start status when a message starts.
// - Link 3 receive sets start status when a message starts.
// - Link 3 transmit sets done status when a message is sent.
// - Link 3 status bits show events since last read or write-one clear; read clears.
// - Receive done rises on full message or on full receive buffer.
module hlis_top #(
    parameter int OVERSIZE_BYTES = `HLIS_OVERSIZE_BYTES
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [17:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic l2_rx_bit_valid,
    input wire logic l2_rx_bit,
    input wire logic l2_rx_check_error,
    input wire logic l2_rx_msg_start,
    input wire logic l2_rx_byte_strobe,
    input wire logic l3_tx_msg_start,
    input wire logic l3_tx_msg_end,
    input wire logic l3_rx_msg_start,
    input wire logic l3_rx_msg_complete,
    input wire logic l3_rx_buf_full,
    input wire logic l3_rx_kind,
    output logic irq
);
    import hlis_pkg::*;

    localparam logic [8:0] OVS_LIMIT = 9'(OVERSIZE_BYTES);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    hlis_bus_e bus_q, bus_d;
    logic [31:0] rdata_d;
    logic wait_d;
    hlis_byte_t ier2_q, ier2_d;
    hlis_byte_t ovs_en_q, ovs_en_d;
    hlis_byte_t ier3_q, ier3_d;
    logic kind_q, kind_d;
    logic [8:0] cnt_q, cnt_d;
    logic ovs_ev_q, ovs_ev_d;
    logic irq_d;
    logic abort_ev, flag_ev;
    logic [7:0] ev_set, ev_clr, st, en;
    logic take, hit_rd, hit_wr;
    hlis_idx_t idx;
    hlis_byte_t wbyte;

    // ****************************************************************
    // Event sources
    // ****************************************************************
    hlis_flag_detect u_detect (
        .mclk(mclk),
        .rst_b(rst_b),
        .bit_valid(l2_rx_bit_valid),
        .bit_in(l2_rx_bit),
        .abort_pulse(abort_ev),
        .flag_pulse(flag_ev)
    );

    // Byte counter of the current link 2 message; fires once past limit
    always_comb begin
        cnt_d = cnt_q;
        ovs_ev_d = 1'b0;
        if (l2_rx_msg_start) begin
            cnt_d = 9'h000;
        end else if (l2_rx_byte_strobe && cnt_q <= OVS_LIMIT) begin
            cnt_d = cnt_q + 9'h001;
            ovs_ev_d = (cnt_q == OVS_LIMIT);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            cnt_q <= 9'h000;
            ovs_ev_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            ovs_ev_q <= ovs_ev_d;
        end
    end

    // Event vector in summary layout
    always_comb begin
        ev_set = 8'h00;
        ev_set[`HLIS_EV_FLAG2] = flag_ev;
        ev_set[`HLIS_EV_ABORT2] = abort_ev;
        ev_set[`HLIS_EV_CHECK2] = l2_rx_check_error;
        ev_set[`HLIS_EV_OVS2] = ovs_ev_q;
        ev_set[`HLIS_EV_RX_DONE3] = l3_rx_msg_complete | l3_rx_buf_full;
        ev_set[`HLIS_EV_TX_DONE3] = l3_tx_msg_end;
        ev_set[`HLIS_EV_RX_START3] = l3_rx_msg_start;
        ev_set[`HLIS_EV_TX_START3] = l3_tx_msg_start;
    end

    hlis_sticky #(
        .N(8)
    ) u_sticky (
        .mclk(mclk),
        .rst_b(rst_b),
        .set_in(ev_set),
        .clr_in(ev_clr),
        .flag_q(st)
    );

    // ****************************************************************
    // Bus decode
    // ****************************************************************
    // Requests are served one cycle after they appear; the ack cycle
    // blocks a second take while the master is still releasing
    always_comb begin
        idx = avs_address[17:2];
        wbyte = avs_writedata[7:0];
        take = (bus_q == HLIS_BUS_IDLE) && (avs_read || avs_write);
        hit_rd = take && avs_read;
        hit_wr = take && avs_write && avs_byteenable[0];
    end

    // Clear-on-read of the status registers plus write-one clear
    always_comb begin
        ev_clr = 8'h00;
        if (hit_rd && idx == `HLIS_IDX_L2_STATUS) begin
            ev_clr[2:0] = 3'h7;
        end
        if (hit_rd && idx == `HLIS_IDX_L2_OVS_STATUS) begin
            ev_clr[`HLIS_EV_OVS2] = 1'b1;
        end
        if (hit_rd && idx == `HLIS_IDX_L3_STATUS) begin
            ev_clr[7:4] = 4'hf;
        end
        if (hit_wr && idx == `HLIS_IDX_CLEAR) begin
            ev_clr = ev_clr | wbyte;
        end
    end

    // Control registers and answer
    always_comb begin
        bus_d = HLIS_BUS_IDLE;
        wait_d = 1'b1;
        rdata_d = avs_readdata;
        ier2_d = ier2_q;
        ovs_en_d = ovs_en_q;
        ier3_d = ier3_q;
        kind_d = l3_rx_kind;
        if (take) begin
            bus_d = HLIS_BUS_ACK;
            wait_d = 1'b0;
            rdata_d = 32'h0000_0000;
            case (idx)
                `HLIS_IDX_L2_STATUS: begin
                    rdata_d[2:0] = st[2:0];
                end
                `HLIS_IDX_L2_IRQ_EN: begin
                    rdata_d[2:0] = ier2_q[2:0];
                end
                `HLIS_IDX_L2_OVS_STATUS: begin
                    rdata_d[`HLIS_L2_OVS_BIT] = st[`HLIS_EV_OVS2];
                end
                `HLIS_IDX_L2_OVS_EN: begin
                    rdata_d[`HLIS_L2_OVS_BIT] = ovs_en_q[`HLIS_L2_OVS_BIT];
                end
                `HLIS_IDX_L3_STATUS: begin
                    rdata_d[`HLIS_L3_KIND_BIT] = kind_q;
                    rdata_d[6:3] = {st[7], st[6], st[5], st[4]};
                end
                `HLIS_IDX_L3_IRQ_EN: begin
                    rdata_d[6:3] = ier3_q[6:3];
                end
                `HLIS_IDX_SUMMARY: begin
                    rdata_d[7:0] = st;
                end
                default: begin
                    rdata_d = 32'h0000_0000;
                end
            endcase
        end
        if (hit_wr) begin
            case (idx)
                `HLIS_IDX_L2_IRQ_EN: begin
                    ier2_d = {5'h00, wbyte[2:0]};
                end
                `HLIS_IDX_L2_OVS_EN: begin
                    ovs_en_d = {7'h00, wbyte[0]};
                end
                `HLIS_IDX_L3_IRQ_EN: begin
                    ier3_d = {1'b0, wbyte[6:3], 3'h0};
                end
                default: begin
                    ier2_d = ier2_q;
                end
            endcase
        end
    end

    // Enable vector in summary layout gates the interrupt line
    always_comb begin
        en = {ier3_q[`HLIS_L3_TX_START_BIT], ier3_q[`HLIS_L3_RX_START_BIT],
            ier3_q[`HLIS_L3_TX_DONE_BIT], ier3_q[`HLIS_L3_RX_DONE_BIT],
            ovs_en_q[`HLIS_L2_OVS_BIT], ier2_q[2:0]};
        irq_d = |(st & en);
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            bus_q <= HLIS_BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
            ier2_q <= `HLIS_RESET_BYTE;
            ovs_en_q <= `HLIS_RESET_BYTE;
            ier3_q <= `HLIS_RESET_BYTE;
            kind_q <= 1'b0;
            irq <= 1'b0;
        end else begin
            bus_q <= bus_d;
            avs_waitrequest <= wait_d;
            avs_readdata <= rdata_d;
            ier2_q <= ier2_d;
            ovs_en_q <= ovs_en_d;
            ier3_q <= ier3_d;
            kind_q <= kind_d;
            irq <= irq_d;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    sequence s_oversize_read;
        hit_rd && idx == `HLIS_IDX_L2_OVS_STATUS && !ev_set[`HLIS_EV_OVS2];
    endsequence

    check_irq_gate_a: assert property (@(posedge mclk) disable iff (!rst_b)
        st[`HLIS_EV_CHECK2] && !ier2_q[`HLIS_L2_CHECK_BIT]
            && (st & en) == 8'h00 |=> !irq)
        else $error("check error interrupt not gated by enable");

    oversize_count_a: assert property (@(posedge mclk) disable iff (!rst_b)
        ovs_ev_q |-> $past(cnt_q) == OVS_LIMIT)
        else $error("oversize event not after limit byte");

    oversize_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
        st[`HLIS_EV_OVS2] && !ev_clr[`HLIS_EV_OVS2] |=> st[`HLIS_EV_OVS2])
        else $error("oversize status lost without read");

    oversize_clear_a: assert property (@(posedge mclk) disable iff (!rst_b)
        s_oversize_read |=> !st[`HLIS_EV_OVS2] ##1 avs_waitrequest)
        else $error("oversize status not cleared by read");

    kind_read_a: assert property (@(posedge mclk) disable iff (!rst_b)
        hit_rd && idx == `HLIS_IDX_L3_STATUS
            |=> avs_readdata[`HLIS_L3_KIND_BIT] == $past(kind_q))
        else $error("kind bit read wrong");

    start_set_a: assert property (@(posedge mclk) disable iff (!rst_b)
        l3_tx_msg_start |=> st[`HLIS_EV_TX_START3])
        else $error("transmit start not recorded");

    rx_done_set_a: assert property (@(posedge mclk) disable iff (!rst_b)
        l3_rx_buf_full || l3_rx_msg_complete |=> st[`HLIS_EV_RX_DONE3])
        else $error("receive done not recorded");

    irq_level_a: assert property (@(posedge mclk) disable iff (!rst_b)
        ##1 irq == |($past(st) & $past(en)))
        else $error("interrupt line disagrees with enabled status");

    bus_ack_a: assert property (@(posedge mclk) disable iff (!rst_b)
        take |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one cycle");

endmodule : hlis_top

// file: verification/hlis_host_model.sv
// Host processor model speaking Avalon-MM to the link interrupt block
`timescale 1ns/10ps

// ****************************************************************
// Host bus master
// ****************************************************************
module hlis_host_model (
    input wire logic mclk,
    output logic [17:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    output logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest
);
    import hlis_pkg::*;

    // Idle bus at time zero
    initial begin
        avs_address = 18'h00000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        avs_byteenable = 4'h0;
    end

    // Hold the request until waitrequest is sampled low; no fixed latency
    task automatic wait_ack();
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge mclk);
        end
    endtask : wait_ack

    // Released address and data show the inverse and byteenable drops to zero, so stale values never look valid
    task automatic release_bus();
        avs_address <= ~avs_address;
        avs_writedata <= ~avs_writedata;
        avs_byteenable <= 4'h0;
    endtask : release_bus

    task automatic bus_write(input hlis_idx_t idx, input hlis_byte_t data);
        @(posedge mclk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h000000, data};
        avs_byteenable <= 4'h1;
        avs_write <= 1'b1;
        wait_ack();
        avs_write <= 1'b0;
        release_bus();
    endtask : bus_write

    task automatic bus_read(input hlis_idx_t idx, output logic [31:0] data);
        @(posedge mclk);
        avs_address <= {idx, 2'b00};
        avs_byteenable <= 4'hf;
        avs_read <= 1'b1;
        wait_ack();
        data = avs_readdata;
        avs_read <= 1'b0;
        release_bus();
    endtask : bus_read
endmodule : hlis_host_model

// file: verification/test_hlis_top.sv
// Self-checking testbench of the link interrupt block
`timescale 1ns/10ps
`include "hlis_regs.svh"

// ****************************************************************
// Bench top
// ****************************************************************
module test_hlis_top;
    import hlis_pkg::*;

    logic mclk, rst_b, avs_read, avs_write, avs_waitrequest, irq;
    logic [17:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    logic [7:0] ev;
    logic bit_valid, bit_in, kind;
    int n_errors, checks;
    int cycles = 0;

    // Short oversize count keeps messages brief
    hlis_top #(.OVERSIZE_BYTES(4)) u_dut (
        .mclk(mclk), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .l2_rx_bit_valid(bit_valid), .l2_rx_bit(bit_in),
        .l2_rx_check_error(ev[0]), .l2_rx_msg_start(ev[1]),
        .l2_rx_byte_strobe(ev[2]), .l3_tx_msg_start(ev[3]),
        .l3_tx_msg_end(ev[4]), .l3_rx_msg_start(ev[5]),
        .l3_rx_msg_complete(ev[6]), .l3_rx_buf_full(ev[7]),
        .l3_rx_kind(kind), .irq(irq)
    );

    hlis_host_model u_host (
        .mclk(mclk), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest)
    );

    // 40 MHz clock
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic rd_chk(input hlis_idx_t idx, input hlis_byte_t exp);
        logic [31:0] d;
        u_host.bus_read(idx, d);
        chk(d, {24'h000000, exp});
    endtask : rd_chk

    // Irq is looked at n edges later, once that edge has settled
    task automatic irq_after(input int n, input logic exp);
        repeat (n) @(posedge mclk);
        #1;
        chk({31'h0, irq}, {31'h0, exp});
    endtask : irq_after

    // One-cycle event pulse on a single event input
    task automatic pulse(input int b);
        @(posedge mclk);
        ev[b] <= 1'b1;
        @(posedge mclk);
        ev[b] <= 1'b0;
    endtask : pulse

    // Bits go out newest last, one strobe every other cycle
    task automatic send_bits(input logic [7:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge mclk);
            bit_valid <= 1'b1;
            bit_in <= v[i];
            @(posedge mclk);
            bit_valid <= 1'b0;
            bit_in <= ~v[i];
        end
    endtask : send_bits

    task automatic test_reset_values();
        hlis_idx_t regs[7] = '{`HLIS_IDX_L2_STATUS, `HLIS_IDX_L2_IRQ_EN,
            `HLIS_IDX_L2_OVS_STATUS, `HLIS_IDX_L2_OVS_EN, `HLIS_IDX_L3_STATUS,
            `HLIS_IDX_L3_IRQ_EN, 16'h0100};
        foreach (regs[i]) rd_chk(regs[i], 8'h00);
        irq_after(0, 1'b0);
        u_host.bus_write(16'h0100, 8'hff);
        rd_chk(16'h0100, 8'h00);
    endtask : test_reset_values

    task automatic test_check_error();
        u_host.bus_write(`HLIS_IDX_L2_IRQ_EN, 8'h04);
        rd_chk(`HLIS_IDX_L2_IRQ_EN, 8'h04);
        pulse(0);
        irq_after(1, 1'b1);
        rd_chk(`HLIS_IDX_L2_STATUS, 8'h04);
        irq_after(0, 1'b0);
        u_host.bus_write(`HLIS_IDX_L2_IRQ_EN, 8'h00);
        pulse(0);
        irq_after(1, 1'b0);
        rd_chk(`HLIS_IDX_L2_STATUS, 8'h04);
    endtask : test_check_error

    task automatic test_abort_flag();
        u_host.bus_write(`HLIS_IDX_L2_IRQ_EN, 8'h03);
        send_bits(8'h3f, 6);
        irq_after(2, 1'b0);
        send_bits(8'h01, 1);
        irq_after(2, 1'b1);
        rd_chk(`HLIS_IDX_L2_STATUS, 8'h02);
        irq_after(0, 1'b0);
        send_bits(8'h7e, 8);
        irq_after(2, 1'b1);
        rd_chk(`HLIS_IDX_L2_STATUS, 8'h01);
    endtask : test_abort_flag

    task automatic test_oversize();
        u_host.bus_write(`HLIS_IDX_L2_OVS_EN, 8'h01);
        rd_chk(`HLIS_IDX_L2_OVS_EN, 8'h01);
        pulse(1);
        repeat (4) pulse(2);
        irq_after(2, 1'b0);
        pulse(2);
        irq_after(2, 1'b1);
        irq_after(8, 1'b1);
        rd_chk(`HLIS_IDX_L2_OVS_STATUS, 8'h01);
        irq_after(0, 1'b0);
        rd_chk(`HLIS_IDX_L2_OVS_STATUS, 8'h00);
        u_host.bus_write(`HLIS_IDX_L2_OVS_EN, 8'h00);
        pulse(1);
        repeat (5) pulse(2);
        irq_after(2, 1'b0);
        rd_chk(`HLIS_IDX_L2_OVS_STATUS, 8'h01);
    endtask : test_oversize

    task automatic test_link3_status();
        u_host.bus_write(`HLIS_IDX_L3_IRQ_EN, 8'h40);
        pulse(3);
        irq_after(1, 1'b1);
        rd_chk(`HLIS_IDX_L3_STATUS, 8'h40);
        irq_after(0, 1'b0);
        // Receive start, transmit done and receive complete, none of them enabled
        pulse(5);
        pulse(4); // Transmit done, its enable clear
        pulse(6);
        irq_after(1, 1'b0);
        rd_chk(`HLIS_IDX_L3_STATUS, 8'h38);
        rd_chk(`HLIS_IDX_L3_STATUS, 8'h00);
        u_host.bus_write(`HLIS_IDX_L3_IRQ_EN, 8'h08);
        pulse(7);
        irq_after(1, 1'b1);
        // Buffer full alone sets the same done bit as a complete message
        rd_chk(`HLIS_IDX_L3_STATUS, 8'h08);
    endtask : test_link3_status

    task automatic test_kind_clear();
        @(posedge mclk);
        kind <= 1'b1;
        rd_chk(`HLIS_IDX_L3_STATUS, 8'h80);
        rd_chk(`HLIS_IDX_L3_STATUS, 8'h80);
        @(posedge mclk);
        kind <= 1'b0;
        rd_chk(`HLIS_IDX_L3_STATUS, 8'h00);
        u_host.bus_write(`HLIS_IDX_L3_IRQ_EN, 8'h40);
        pulse(3);
        irq_after(1, 1'b1);
        rd_chk(`HLIS_IDX_SUMMARY, 8'h80);
        u_host.bus_write(`HLIS_IDX_CLEAR, 8'h80);
        irq_after(0, 1'b0);
        rd_chk(`HLIS_IDX_L3_STATUS, 8'h00);
    endtask : test_kind_clear

    task automatic finish_test();
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    // Hang guard: the whole run needs far fewer cycles than this
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            finish_test();
        end
    end

    // Main sequence
    initial begin
        rst_b = 1'b0;
        ev = 8'h00;
        bit_valid = 1'b0;
        bit_in = 1'b0;
        kind = 1'b0;
        n_errors = 0;
        checks = 0;
        repeat (6) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        test_reset_values();
        test_check_error();
        test_abort_flag();
        test_oversize();
        test_link3_status();
        test_kind_clear();
        finish_test();
    end
endmodule : test_hlis_top
